// ### design/hsd_defs.svh
`ifndef HSD_DEFS_SVH
`define HSD_DEFS_SVH

// =====================================================================
// Widths and counts
`define HSD_LEN_W      11
`define HSD_ADDR_W     32
`define HSD_BANK_MAX   3
`define HSD_CNT_W      2
`define HSD_ALIGN_BITS 4

// =====================================================================
// Reset values
`define HSD_LEN_ZERO   11'h000
`define HSD_CNT_ZERO   2'h0
`define HSD_CNT_ONE    2'h1
`define HSD_ADDR_ZERO  32'h0000_0000

`endif

// ### design/hsd_dma.sv
`include "hsd_defs.svh"

module hsd_dma #(
  parameter int LW = `HSD_LEN_W,
  parameter int AW = `HSD_ADDR_W
) (
  // Clock and reset.
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  // Channel control.
  input  wire hsd_pkg::hsd_desc_s ctl_i,
  input  wire logic               ctl_wr_i,
  input  wire logic               allowed_i,
  input  wire logic               halt_i,
  // Descriptor fetch and data beats.
  output logic                    fetch_req_o,
  output logic [AW-1:0]           fetch_addr_o,
  input  wire logic               fetch_ack_i,
  input  wire hsd_pkg::hsd_desc_s fetch_data_i,
  output logic                    beat_req_o,
  output logic [AW-1:0]           beat_addr_o,
  input  wire logic               beat_ack_i,
  // Status.
  output logic [LW-1:0]           remain_o,
  output logic                    done_o,
  output logic                    end_irq_o
);

  typedef enum logic [1:0] {HSD_DMA_IDLE, HSD_DMA_FETCH, HSD_DMA_MOVE} hsd_dma_e;

  hsd_dma_e           state_r;
  hsd_pkg::hsd_desc_s cur_r;

  // =====================================================================
  // Channel sequencer: optional descriptor fetch, then byte beats.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r   <= HSD_DMA_IDLE;
      cur_r     <= '0;
      remain_o  <= `HSD_LEN_ZERO;
      done_o    <= 1'b0;
      end_irq_o <= 1'b0;
    end else begin
      end_irq_o <= 1'b0;
      if (halt_i || !allowed_i) begin
        state_r <= HSD_DMA_IDLE;
      end else if (ctl_wr_i) begin
        cur_r    <= ctl_i;
        remain_o <= ctl_i.len;
        done_o   <= 1'b0;
        if (ctl_i.load_next) begin
          state_r <= HSD_DMA_FETCH;
        end else if (ctl_i.run) begin
          state_r <= HSD_DMA_MOVE;
        end else begin
          state_r <= HSD_DMA_IDLE;
        end
      end else begin
        case (state_r)
          HSD_DMA_FETCH: begin
            if (fetch_ack_i) begin
              cur_r    <= fetch_data_i;
              remain_o <= fetch_data_i.len;
              state_r  <= fetch_data_i.run ? HSD_DMA_MOVE : HSD_DMA_IDLE;
            end
          end
          HSD_DMA_MOVE: begin
            if (remain_o == `HSD_LEN_ZERO) begin
              // Completion status is written in the same cycle as chaining on.
              done_o    <= 1'b1;
              end_irq_o <= cur_r.end_irq_en;
              state_r   <= cur_r.load_next ? HSD_DMA_FETCH : HSD_DMA_IDLE;
            end else if (beat_ack_i) begin
              remain_o   <= remain_o - LW'(1);
              cur_r.addr <= cur_r.addr + AW'(1);
            end
          end
          default: state_r <= HSD_DMA_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // Bus requests are registered so the master sees clean levels.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fetch_req_o  <= 1'b0;
      fetch_addr_o <= `HSD_ADDR_ZERO;
      beat_req_o   <= 1'b0;
      beat_addr_o  <= `HSD_ADDR_ZERO;
    end else begin
      fetch_req_o  <= (state_r == HSD_DMA_FETCH) && !fetch_ack_i && !halt_i;
      // Low bits are forced to zero: descriptors must sit aligned.
      fetch_addr_o <= {cur_r.next[AW-1:`HSD_ALIGN_BITS], `HSD_ALIGN_BITS'(0)};
      beat_req_o   <= (state_r == HSD_DMA_MOVE) && (remain_o != `HSD_LEN_ZERO) && !halt_i;
      beat_addr_o  <= cur_r.addr;
    end
  end

  property p_dma_halt;
    @(posedge ref_clk_i) disable iff (rst_i)
    halt_i |=> (state_r == HSD_DMA_IDLE) && !end_irq_o;
  endproperty
  a_dma_halt: assert property (p_dma_halt) else $error("DMA kept running after halt.");

  property p_dma_end_irq;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_r == HSD_DMA_MOVE) && (remain_o == `HSD_LEN_ZERO) && cur_r.end_irq_en && !halt_i && allowed_i && !ctl_wr_i
      |=> end_irq_o && done_o;
  endproperty
  a_dma_end_irq: assert property (p_dma_end_irq) else $error("Buffer end interrupt missing.");

endmodule : hsd_dma

// ### design/hsd_endpoint.sv
// Contract
// - Setup data held; others refused until cleared.
// - Valid setup: ACK, store, flag, count.
// - Interrupt follows setup flag when enabled.
// - Setup token clears stall-sent, still accepted.
// - Hardware NYET/ACK/PING; disable forces NAK.
// - NYET means accepted but no room.
// - Interrupt when a new packet fits.
// - Auto validation on last bank byte; not done on iso endpoints.
// - Interrupt once all banks free.
// - Ready with no payload sends ZLP.
// - DMA for all but control endpoints.
// - Buffer-end interrupt when count hits zero.
// - Aligned descriptor fetched before buffer.
// - Chained descriptors, status on completion.
// - Enabled interrupt halts DMA when asked.
// - First status-stage token gets NAK.
// - Iso IN empty: silence, underflow flag.
`include "hsd_defs.svh"

module hsd_endpoint #(
  parameter int LW = `HSD_LEN_W,
  parameter int AW = `HSD_ADDR_W,
  parameter int NB = `HSD_BANK_MAX
) (
  // Clock and reset.
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  // Link side: tokens and answers.
  input  wire hsd_pkg::hsd_tok_s  tok_i,
  output hsd_pkg::hsd_ans_s       ans_o,
  // Endpoint configuration.
  input  wire hsd_pkg::hsd_ep_e   ep_type_i,
  input  wire logic [1:0]         bank_num_i,
  input  wire logic [LW-1:0]      bank_size_i,
  input  wire logic               nyet_disable_i,
  input  wire logic               auto_valid_i,
  input  wire logic               stall_req_i,
  input  wire logic               irq_halts_dma_i,
  input  wire hsd_pkg::hsd_irq_s  irq_en_i,
  // Software strobes.
  input  wire logic               setup_clear_i,
  input  wire logic               stall_clear_i,
  input  wire logic               iso_err_clear_i,
  input  wire logic               tx_ready_set_i,
  input  wire logic               buf_wr_i,
  input  wire logic               rx_bank_release_i,
  // Status.
  output logic                    setup_flag_o,
  output logic                    stall_sent_flag_o,
  output logic                    tx_packet_ready_o,
  output logic                    rx_bank_ready_o,
  output logic                    iso_underflow_error_o,
  output logic [1:0]              busy_bank_count_o,
  output logic [LW-1:0]           byte_count_o,
  output logic                    ep_irq_o,
  // DMA channel.
  input  wire hsd_pkg::hsd_desc_s dma_ctl_i,
  input  wire logic               dma_ctl_wr_i,
  output logic                    dma_fetch_req_o,
  output logic [AW-1:0]           dma_fetch_addr_o,
  input  wire logic               dma_fetch_ack_i,
  input  wire hsd_pkg::hsd_desc_s dma_fetch_data_i,
  output logic                    dma_beat_req_o,
  output logic [AW-1:0]           dma_beat_addr_o,
  input  wire logic               dma_beat_ack_i,
  output logic [LW-1:0]           dma_remain_o,
  output logic                    dma_done_o,
  output logic                    dma_end_irq_o
);

  // =====================================================================
  // Bank bookkeeping
  logic [LW-1:0] bank_len_r [NB];
  logic [1:0]    wr_idx_r;
  logic [1:0]    rd_idx_r;
  logic [LW-1:0] wr_cnt_r;
  logic          status_nak_done_r;
  hsd_pkg::hsd_irq_s irq_raw;

  // Wraps a bank index at the configured bank count.
  function automatic logic [1:0] next_idx(input logic [1:0] idx, input logic [1:0] num);
    next_idx = (idx + 2'h1 >= num) ? 2'h0 : idx + 2'h1;
  endfunction : next_idx

  // =====================================================================
  // Token decode (same clock as the link logic, no synchroniser).
  logic   is_iso;
  logic   room;
  logic   full_after;
  logic   tok_setup;
  logic   tok_out;
  logic   tok_in;
  logic   tok_ping;
  logic   any_buf_wr;
  logic   auto_fill;
  logic   sw_valid;
  logic   out_take;
  logic   in_send;
  logic   iso_miss;
  logic   status_nak;
  logic   dma_beat_wr;

  assign is_iso      = (ep_type_i == hsd_pkg::HSD_EP_ISO);
  assign room        = (busy_bank_count_o < bank_num_i);
  assign full_after  = (busy_bank_count_o + 2'h1 >= bank_num_i);
  assign tok_setup   = tok_i.vld && (tok_i.kind == hsd_pkg::HSD_TOK_SETUP);
  assign tok_out     = tok_i.vld && (tok_i.kind == hsd_pkg::HSD_TOK_OUT);
  assign tok_in      = tok_i.vld && (tok_i.kind == hsd_pkg::HSD_TOK_IN);
  assign tok_ping    = tok_i.vld && (tok_i.kind == hsd_pkg::HSD_TOK_PING);
  // The status-stage NAK applies to every endpoint type except isochronous.
  assign status_nak  = tok_i.vld && tok_i.status && !status_nak_done_r && !is_iso && !setup_flag_o;
  assign dma_beat_wr = dma_beat_req_o && dma_beat_ack_i;
  assign any_buf_wr  = (buf_wr_i || dma_beat_wr) && room;
  // Auto validation is refused on iso endpoints since banks do not ping-pong there.
  assign auto_fill   = any_buf_wr && auto_valid_i && !is_iso && (wr_cnt_r + LW'(1) == bank_size_i);
  assign sw_valid    = tx_ready_set_i && room;
  assign out_take    = tok_out && !setup_flag_o && !status_nak && !stall_req_i && room;
  assign in_send     = tok_in && !setup_flag_o && !status_nak && !stall_req_i && (busy_bank_count_o != 2'h0);
  assign iso_miss    = tok_in && is_iso && (busy_bank_count_o == 2'h0);

  // =====================================================================
  // Handshake answer, one cycle after the token.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ans_o <= '0;
    end else begin
      ans_o.len  <= `HSD_LEN_ZERO;
      ans_o.code <= hsd_pkg::HSD_HS_NONE;
      if (tok_setup) begin
        // A setup is refused only while the previous one is unread.
        ans_o.code <= setup_flag_o ? hsd_pkg::HSD_HS_NONE : hsd_pkg::HSD_HS_ACK;
      end else if (tok_i.vld && setup_flag_o) begin
        ans_o.code <= hsd_pkg::HSD_HS_NAK;
      end else if (status_nak) begin
        ans_o.code <= hsd_pkg::HSD_HS_NAK;
      end else if (tok_i.vld && stall_req_i && !is_iso) begin
        ans_o.code <= hsd_pkg::HSD_HS_STALL;
      end else if (iso_miss) begin
        ans_o.code <= hsd_pkg::HSD_HS_NONE;
      end else if (in_send) begin
        ans_o.code <= hsd_pkg::HSD_HS_DATA;
        ans_o.len  <= bank_len_r[rd_idx_r];
      end else if (tok_in) begin
        ans_o.code <= hsd_pkg::HSD_HS_NAK;
      end else if (tok_ping) begin
        ans_o.code <= room ? hsd_pkg::HSD_HS_ACK : hsd_pkg::HSD_HS_NAK;
      end else if (tok_out) begin
        if (!room || is_iso) begin
          ans_o.code <= room ? hsd_pkg::HSD_HS_NONE : hsd_pkg::HSD_HS_NAK;
        end else if (full_after && ep_type_i == hsd_pkg::HSD_EP_BULK) begin
          ans_o.code <= nyet_disable_i ? hsd_pkg::HSD_HS_NAK : hsd_pkg::HSD_HS_NYET;
        end else begin
          ans_o.code <= hsd_pkg::HSD_HS_ACK;
        end
      end
    end
  end

  // =====================================================================
  // Setup and stall flags; a hardware set beats a software clear.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      setup_flag_o      <= 1'b0;
      stall_sent_flag_o <= 1'b0;
      byte_count_o      <= `HSD_LEN_ZERO;
      status_nak_done_r <= 1'b0;
    end else begin
      if (tok_setup && !setup_flag_o) begin
        setup_flag_o      <= 1'b1;
        byte_count_o      <= tok_i.len;
        stall_sent_flag_o <= 1'b0;
        status_nak_done_r <= 1'b0;
      end else begin
        if (setup_clear_i) begin
          setup_flag_o <= 1'b0;
        end
        if (tok_i.vld && stall_req_i && !is_iso && !setup_flag_o && !status_nak) begin
          stall_sent_flag_o <= 1'b1;
        end else if (stall_clear_i) begin
          stall_sent_flag_o <= 1'b0;
        end
        if (status_nak) begin
          status_nak_done_r <= 1'b1;
        end
        if (out_take) begin
          byte_count_o <= tok_i.len;
        end
      end
    end
  end

  // =====================================================================
  // Bank queue: fill by writes, OUT data or validation; drain by IN or release.
  logic inc;
  logic dec;
  assign inc = out_take || auto_fill || (sw_valid && !auto_fill);
  assign dec = in_send || (rx_bank_release_i && busy_bank_count_o != 2'h0);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_bank_count_o <= `HSD_CNT_ZERO;
      wr_idx_r          <= `HSD_CNT_ZERO;
      rd_idx_r          <= `HSD_CNT_ZERO;
      wr_cnt_r          <= `HSD_LEN_ZERO;
      for (int i = 0; i < NB; i++) begin
        bank_len_r[i] <= `HSD_LEN_ZERO;
      end
    end else begin
      busy_bank_count_o <= busy_bank_count_o + (inc ? 2'h1 : 2'h0) - (dec ? 2'h1 : 2'h0);
      if (inc) begin
        wr_idx_r <= next_idx(wr_idx_r, bank_num_i);
      end
      if (dec) begin
        rd_idx_r <= next_idx(rd_idx_r, bank_num_i);
      end
      if (out_take) begin
        bank_len_r[wr_idx_r] <= tok_i.len;
      end else if (auto_fill) begin
        bank_len_r[wr_idx_r] <= bank_size_i;
        wr_cnt_r             <= `HSD_LEN_ZERO;
      end else if (sw_valid) begin
        // A tail left by the writer is sent as a short packet, or a ZLP.
        bank_len_r[wr_idx_r] <= wr_cnt_r + (any_buf_wr ? LW'(1) : LW'(0));
        wr_cnt_r             <= `HSD_LEN_ZERO;
      end else if (any_buf_wr) begin
        wr_cnt_r <= wr_cnt_r + LW'(1);
      end
    end
  end

  // =====================================================================
  // Status flags and the endpoint interrupt.
  assign irq_raw.setup     = setup_flag_o;
  assign irq_raw.tx_ready  = (busy_bank_count_o < bank_num_i);
  assign irq_raw.bank_free = (busy_bank_count_o == 2'h0);
  assign irq_raw.iso_err   = iso_underflow_error_o;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      iso_underflow_error_o <= 1'b0;
      tx_packet_ready_o     <= 1'b0;
      rx_bank_ready_o       <= 1'b0;
      ep_irq_o              <= 1'b0;
    end else begin
      if (iso_miss) begin
        iso_underflow_error_o <= 1'b1;
      end else if (iso_err_clear_i) begin
        iso_underflow_error_o <= 1'b0;
      end
      tx_packet_ready_o <= (busy_bank_count_o != 2'h0);
      rx_bank_ready_o   <= (busy_bank_count_o != 2'h0);
      ep_irq_o          <= |(irq_raw & irq_en_i);
    end
  end

  // =====================================================================
  // DMA channel, refused on control endpoints.
  hsd_dma #(
    .LW (LW),
    .AW (AW)
  ) u_dma (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .ctl_i        (dma_ctl_i),
    .ctl_wr_i     (dma_ctl_wr_i),
    .allowed_i    (ep_type_i != hsd_pkg::HSD_EP_CTRL),
    .halt_i       (irq_halts_dma_i && ep_irq_o),
    .fetch_req_o  (dma_fetch_req_o),
    .fetch_addr_o (dma_fetch_addr_o),
    .fetch_ack_i  (dma_fetch_ack_i),
    .fetch_data_i (dma_fetch_data_i),
    .beat_req_o   (dma_beat_req_o),
    .beat_addr_o  (dma_beat_addr_o),
    .beat_ack_i   (dma_beat_ack_i),
    .remain_o     (dma_remain_o),
    .done_o       (dma_done_o),
    .end_irq_o    (dma_end_irq_o)
  );

  // =====================================================================
  // Checks.
  sequence s_setup_taken;
    tok_setup && !setup_flag_o;
  endsequence

  sequence s_setup_done;
    (ans_o.code == hsd_pkg::HSD_HS_ACK) && setup_flag_o && (byte_count_o == $past(tok_i.len));
  endsequence

  property p_setup_ack;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_setup_taken |=> s_setup_done;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("Setup not acknowledged and stored.");

  property p_setup_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
    setup_flag_o && tok_i.vld && !tok_setup |=> ans_o.code == hsd_pkg::HSD_HS_NAK;
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("Token served while setup unread.");

  property p_setup_irq;
    @(posedge ref_clk_i) disable iff (rst_i)
    setup_flag_o && irq_en_i.setup |=> ep_irq_o;
  endproperty
  a_setup_irq: assert property (p_setup_irq) else $error("Setup interrupt not raised.");

  property p_stall_clear;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_setup_taken ##0 stall_sent_flag_o |=> !stall_sent_flag_o && setup_flag_o;
  endproperty
  a_stall_clear: assert property (p_stall_clear) else $error("Stall flag survived setup.");

  property p_out_full_nak;
    @(posedge ref_clk_i) disable iff (rst_i)
    tok_out && !room && !setup_flag_o && !status_nak && !stall_req_i |=> ans_o.code == hsd_pkg::HSD_HS_NAK;
  endproperty
  a_out_full_nak: assert property (p_out_full_nak) else $error("Full endpoint did not NAK.");

  property p_nyet;
    @(posedge ref_clk_i) disable iff (rst_i)
    out_take && full_after && ep_type_i == hsd_pkg::HSD_EP_BULK && !nyet_disable_i
      |=> ans_o.code == hsd_pkg::HSD_HS_NYET && busy_bank_count_o == $past(busy_bank_count_o) + 2'h1 - ($past(dec) ? 2'h1 : 2'h0);
  endproperty
  a_nyet: assert property (p_nyet) else $error("NYET not sent on last free bank.");

  property p_auto_valid;
    @(posedge ref_clk_i) disable iff (rst_i)
    auto_fill && !dec && !out_take |=> busy_bank_count_o == $past(busy_bank_count_o) + 2'h1 && wr_cnt_r == `HSD_LEN_ZERO;
  endproperty
  a_auto_valid: assert property (p_auto_valid) else $error("Full bank not validated.");

  property p_iso_miss;
    @(posedge ref_clk_i) disable iff (rst_i)
    iso_miss && !setup_flag_o && !status_nak && !stall_req_i
      |=> ans_o.code == hsd_pkg::HSD_HS_NONE ##1 iso_underflow_error_o;
  endproperty
  a_iso_miss: assert property (p_iso_miss) else $error("Iso underflow mishandled.");

  property p_status_nak;
    @(posedge ref_clk_i) disable iff (rst_i)
    status_nak |=> ans_o.code == hsd_pkg::HSD_HS_NAK && status_nak_done_r;
  endproperty
  a_status_nak: assert property (p_status_nak) else $error("First status token not NAKed.");

endmodule : hsd_endpoint

// ### design/hsd_pkg.sv
`include "hsd_defs.svh"

package hsd_pkg;

  // ===================================================================
  // Enumerations
  typedef enum logic [2:0] {HSD_TOK_NONE, HSD_TOK_SETUP, HSD_TOK_OUT, HSD_TOK_IN, HSD_TOK_PING} hsd_tok_e;
  typedef enum logic [2:0] {HSD_HS_NONE, HSD_HS_ACK, HSD_HS_NAK, HSD_HS_NYET, HSD_HS_STALL, HSD_HS_DATA} hsd_hs_e;
  typedef enum logic [1:0] {HSD_EP_CTRL, HSD_EP_BULK, HSD_EP_INTR, HSD_EP_ISO} hsd_ep_e;

  // ===================================================================
  // Carriers
  typedef struct packed {
    logic                   vld;
    hsd_tok_e               kind;
    logic                   status;
    logic [`HSD_LEN_W-1:0]  len;
  } hsd_tok_s;

  typedef struct packed {
    hsd_hs_e                code;
    logic [`HSD_LEN_W-1:0]  len;
  } hsd_ans_s;

  typedef struct packed {
    logic setup;
    logic tx_ready;
    logic bank_free;
    logic iso_err;
  } hsd_irq_s;

  typedef struct packed {
    logic [`HSD_ADDR_W-1:0] next;
    logic [`HSD_ADDR_W-1:0] addr;
    logic [`HSD_LEN_W-1:0]  len;
    logic                   load_next;
    logic                   run;
    logic                   end_irq_en;
  } hsd_desc_s;

endpackage : hsd_pkg

// ### test/hsd_host_model.sv
module hsd_host_model (
  // Clock.
  input  wire logic              ref_clk_i,
  // Token out, answer in.
  output hsd_pkg::hsd_tok_s      tok_o,
  input  wire hsd_pkg::hsd_ans_s ans_i
);
  timeunit 1ns;
  timeprecision 1ps;

  hsd_pkg::hsd_ans_s last_ans;

  // =====================================================================
  // Token issue
  initial tok_o = '0;

  // One token per call. The answer is taken one cycle later, where it stands.
  // The idle length is inverted, so that a stale value never looks like a fresh token.
  task automatic send(input hsd_pkg::hsd_tok_e kind, input logic status, input logic [10:0] len);
    @(negedge ref_clk_i);
    tok_o <= '{vld: 1'b1, kind: kind, status: status, len: len};
    @(negedge ref_clk_i);
    last_ans = ans_i;
    tok_o.vld <= 1'b0;
    tok_o.len <= ~len;
  endtask : send
endmodule : hsd_host_model

// ### test/usb_device_endpoint_transactions_bench.sv
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module usb_device_endpoint_transactions_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Signals
  logic ref_clk_i, rst_i, nyet_disable_i, auto_valid_i, stall_req_i, irq_halts_dma_i;
  logic setup_clear_i, stall_clear_i, iso_err_clear_i, tx_ready_set_i, buf_wr_i, rx_bank_release_i;
  logic dma_ctl_wr_i, dma_fetch_ack_i, dma_beat_ack_i, dma_fetch_req_o, dma_beat_req_o, dma_done_o, dma_end_irq_o;
  logic setup_flag_o, stall_sent_flag_o, tx_packet_ready_o, rx_bank_ready_o, iso_underflow_error_o, ep_irq_o;
  logic [1:0]         bank_num_i, busy_bank_count_o;
  logic [10:0]        bank_size_i, byte_count_o, dma_remain_o;
  logic [31:0]        dma_fetch_addr_o, dma_beat_addr_o;
  hsd_pkg::hsd_tok_s  tok_i;
  hsd_pkg::hsd_ans_s  ans_o;
  hsd_pkg::hsd_ep_e   ep_type_i;
  hsd_pkg::hsd_irq_s  irq_en_i;
  hsd_pkg::hsd_desc_s dma_ctl_i, dma_fetch_data_i;
  int err_count = 0;
  int tests_run = 0;
  int end_irqs = 0;

  hsd_endpoint uut (.ref_clk_i, .rst_i, .tok_i, .ans_o, .ep_type_i, .bank_num_i, .bank_size_i, .nyet_disable_i,
    .auto_valid_i, .stall_req_i, .irq_halts_dma_i, .irq_en_i, .setup_clear_i, .stall_clear_i, .iso_err_clear_i,
    .tx_ready_set_i, .buf_wr_i, .rx_bank_release_i, .setup_flag_o, .stall_sent_flag_o, .tx_packet_ready_o,
    .rx_bank_ready_o, .iso_underflow_error_o, .busy_bank_count_o, .byte_count_o, .ep_irq_o, .dma_ctl_i,
    .dma_ctl_wr_i, .dma_fetch_req_o, .dma_fetch_addr_o, .dma_fetch_ack_i, .dma_fetch_data_i, .dma_beat_req_o,
    .dma_beat_addr_o, .dma_beat_ack_i, .dma_remain_o, .dma_done_o, .dma_end_irq_o);
  hsd_host_model host (.ref_clk_i, .tok_o(tok_i), .ans_i(ans_o));

  // =====================================================================
  // Clock, memory side and interrupt counting
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Memory acks every other cycle, so the channel also sees a slow slave.
  always @(negedge ref_clk_i) begin
    dma_beat_ack_i <= dma_beat_req_o & ~dma_beat_ack_i;
    dma_fetch_ack_i <= dma_fetch_req_o & ~dma_fetch_ack_i;
  end

  always @(posedge ref_clk_i) if (dma_end_irq_o === 1'b1) end_irqs++;

  // =====================================================================
  // Helpers
  task automatic strobe(input int which);
    @(negedge ref_clk_i);
    {setup_clear_i, tx_ready_set_i, buf_wr_i, rx_bank_release_i, dma_ctl_wr_i} <= 5'h1 << which;
    @(negedge ref_clk_i);
    {setup_clear_i, tx_ready_set_i, buf_wr_i, rx_bank_release_i, dma_ctl_wr_i} <= 5'h00;
  endtask : strobe

  task automatic restart(input hsd_pkg::hsd_ep_e ep, input logic [1:0] nb, input logic [3:0] en);
    @(negedge ref_clk_i);
    rst_i <= 1'b1;
    {ep_type_i, bank_num_i, irq_en_i, bank_size_i} <= {ep, nb, en, 11'h004};
    {nyet_disable_i, auto_valid_i, stall_req_i, irq_halts_dma_i} <= 4'h0;
    repeat (12) @(negedge ref_clk_i);
    rst_i <= 1'b0;
  endtask : restart

  // =====================================================================
  // Scenarios
  task automatic t_setup();
    restart(hsd_pkg::HSD_EP_CTRL, 2'h1, 4'h8);
    stall_req_i <= 1'b1;
    host.send(hsd_pkg::HSD_TOK_IN, 1'b0, 11'h000);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_STALL)
    stall_req_i <= 1'b0;
    `CHK(stall_sent_flag_o, 1'b1)
    host.send(hsd_pkg::HSD_TOK_SETUP, 1'b0, 11'h008);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_ACK)
    `CHK(stall_sent_flag_o, 1'b0)
    `CHK({setup_flag_o, byte_count_o}, {1'b1, 11'h008})
    host.send(hsd_pkg::HSD_TOK_OUT, 1'b0, 11'h004);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_NAK)
    `CHK(ep_irq_o, 1'b1)
    irq_en_i <= 4'h0;
    repeat (2) @(negedge ref_clk_i);
    `CHK(ep_irq_o, 1'b0)
    strobe(4);
    host.send(hsd_pkg::HSD_TOK_IN, 1'b1, 11'h000);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_NAK)
    `CHK(setup_flag_o, 1'b0)
    $display("Test setup done");
  endtask : t_setup

  task automatic t_out();
    restart(hsd_pkg::HSD_EP_BULK, 2'h2, 4'h0);
    host.send(hsd_pkg::HSD_TOK_OUT, 1'b0, 11'h004);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_ACK)
    host.send(hsd_pkg::HSD_TOK_OUT, 1'b0, 11'h004);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_NYET)
    // After a no-room reply the host only pings until space appears.
    host.send(hsd_pkg::HSD_TOK_PING, 1'b0, 11'h000);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_NAK)
    strobe(1);
    host.send(hsd_pkg::HSD_TOK_PING, 1'b0, 11'h000);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_ACK)
    nyet_disable_i <= 1'b1;
    host.send(hsd_pkg::HSD_TOK_OUT, 1'b0, 11'h004);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_NAK)
    `CHK({busy_bank_count_o, rx_bank_ready_o}, {2'h2, 1'b1})
    $display("Test bulk out done");
  endtask : t_out

  task automatic t_in();
    restart(hsd_pkg::HSD_EP_BULK, 2'h2, 4'h2);
    auto_valid_i <= 1'b1;
    repeat (4) strobe(2);
    // Ready flag and interrupt follow the bank count one cycle late.
    @(negedge ref_clk_i);
    `CHK({busy_bank_count_o, tx_packet_ready_o, ep_irq_o}, {2'h1, 1'b1, 1'b0})
    strobe(3);
    `CHK(busy_bank_count_o, 2'h2)
    host.send(hsd_pkg::HSD_TOK_IN, 1'b0, 11'h000);
    `CHK(host.last_ans, {hsd_pkg::HSD_HS_DATA, 11'h004})
    host.send(hsd_pkg::HSD_TOK_IN, 1'b0, 11'h000);
    `CHK(host.last_ans, {hsd_pkg::HSD_HS_DATA, 11'h000})
    @(negedge ref_clk_i);
    `CHK({busy_bank_count_o, ep_irq_o}, {2'h0, 1'b1})
    $display("Test bulk in done");
  endtask : t_in

  task automatic t_iso();
    restart(hsd_pkg::HSD_EP_ISO, 2'h2, 4'h1);
    host.send(hsd_pkg::HSD_TOK_IN, 1'b0, 11'h000);
    `CHK(host.last_ans.code, hsd_pkg::HSD_HS_NONE)
    @(negedge ref_clk_i);
    `CHK(iso_underflow_error_o, 1'b1)
    @(negedge ref_clk_i);
    `CHK(ep_irq_o, 1'b1)
    $display("Test iso done");
  endtask : t_iso

  task automatic t_dma();
    restart(hsd_pkg::HSD_EP_BULK, 2'h3, 4'h0);
    dma_ctl_i <= '{next: 32'h0, addr: 32'h100, len: 11'h3, load_next: 1'b0, run: 1'b1, end_irq_en: 1'b1};
    strobe(0);
    for (int i = 0; i < 60 && end_irqs < 1; i++) @(negedge ref_clk_i);
    `CHK({dma_remain_o, dma_done_o, end_irqs[1:0], dma_beat_addr_o}, {11'h0, 1'b1, 2'h1, 32'h103})
    dma_fetch_data_i <= '{next: 32'h0, addr: 32'h180, len: 11'h2, load_next: 1'b0, run: 1'b1, end_irq_en: 1'b1};
    dma_ctl_i <= '{next: 32'h200, addr: 32'h0, len: 11'h0, load_next: 1'b1, run: 1'b0, end_irq_en: 1'b0};
    strobe(0);
    for (int i = 0; i < 20 && dma_fetch_req_o !== 1'b1; i++) @(negedge ref_clk_i);
    `CHK(dma_fetch_addr_o, 32'h200)
    for (int i = 0; i < 60 && end_irqs < 2; i++) @(negedge ref_clk_i);
    `CHK({dma_remain_o, dma_done_o, end_irqs[1:0]}, {11'h0, 1'b1, 2'h2})
    irq_en_i <= 4'h2;
    irq_halts_dma_i <= 1'b1;
    strobe(0);
    repeat (12) @(negedge ref_clk_i);
    `CHK({dma_beat_req_o, dma_fetch_req_o, end_irqs[1:0]}, {2'h0, 2'h2})
    restart(hsd_pkg::HSD_EP_CTRL, 2'h1, 4'h0);
    strobe(0);
    repeat (10) @(negedge ref_clk_i);
    `CHK({dma_done_o, dma_beat_req_o}, 2'h0)
    $display("Test dma done");
  endtask : t_dma

  // =====================================================================
  // Verdict, sequence and watchdog
  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    rst_i = 1'b1;
    {ep_type_i, bank_num_i, bank_size_i, irq_en_i, dma_ctl_i, dma_fetch_data_i} = '0;
    {nyet_disable_i, auto_valid_i, stall_req_i, irq_halts_dma_i, stall_clear_i, iso_err_clear_i} = '0;
    {setup_clear_i, tx_ready_set_i, buf_wr_i, rx_bank_release_i, dma_ctl_wr_i} = '0;
    t_setup();
    t_out();
    t_in();
    t_iso();
    t_dma();
    end_sim();
  end

  // The scenarios need well under a thousand cycles, so this only fires on a hang.
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    err_count++;
    end_sim();
  end
endmodule : usb_device_endpoint_transactions_bench
